/* File: homing_pkg.sv */
// Shared constants and types for the origin return sequencer
`default_nettype none
package homing_pkg;
   localparam int unsigned CLK_HZ            = 125_000_000;
   localparam int unsigned DELAY_UNIT_US     = 1000;
   localparam int unsigned DELAY_UNIT_CYCLES = CLK_HZ / 1_000_000 * DELAY_UNIT_US;

   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SPEC   = 8'h04;
   localparam logic [7:0] ADDR_CONSTANT_SCAN_SPEED   = 8'h08;
   localparam logic [7:0] ADDR_SPER   = 8'h0c;
   localparam logic [7:0] ADDR_SLOW   = 8'h10;
   localparam logic [7:0] ADDR_DELAY  = 8'h14;
   localparam logic [7:0] ADDR_MARGIN = 8'h18;
   localparam logic [7:0] ADDR_OFFSET = 8'h1c;
   localparam logic [7:0] ADDR_CSLIM  = 8'h20;
   localparam logic [7:0] ADDR_JGLIM  = 8'h24;
   localparam logic [7:0] ADDR_STAT   = 8'h28;

   localparam int unsigned CTRL_START = 0;
   localparam int unsigned CTRL_CW    = 1;
   localparam int unsigned CTRL_TYPE  = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [7:0]  SCAN_DELAY_RST  = 8'h0a;
   localparam logic [7:0]  LIMIT_DELAY_RST = 8'h1e;
   localparam logic [7:0]  JOG_DELAY_RST   = 8'h05;
   localparam logic [15:0] CONSTANT_SCAN_SPEED_RST        = 16'h00ff;
   localparam logic [15:0] SPER_RST        = 16'h003f;
   localparam logic [15:0] SLOW_RST        = 16'h0010;
   localparam logic [15:0] MARGIN_RST      = 16'h0004;

   typedef struct packed {
      logic ignore_level;
      logic servo_drive_end_handshake_enable;
      logic error_pulse_enable;
      logic near_origin_move_enable;
   } spec_t;

   typedef struct packed {
      logic [7:0] jog;
      logic [7:0] limit;
      logic [7:0] scan;
   } delays_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_MOVE  = 3'b001,
      S_TAIL  = 3'b010,
      S_HAND  = 3'b011,
      S_DELAY = 3'b100,
      S_JOG   = 3'b101,
      S_JWAIT = 3'b110
   } state_t;

   typedef enum logic [2:0] {
      P_NEAR  = 3'b000,
      P_SCAN  = 3'b001,
      P_CSCAN = 3'b010,
      P_JOG   = 3'b011,
      P_END   = 3'b100
   } proc_t;
endpackage : homing_pkg
`default_nettype wire

/* File: origin_return_sequencer.sv */
// Homing sequencer with AXI4-Lite register access
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
module origin_return_sequencer #(
   parameter int unsigned DELAY_UNIT = homing_pkg::DELAY_UNIT_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        origin_sensor,
   input  wire logic        near_origin_sensor,
   input  wire logic        cw_limit_input,
   input  wire logic        ccw_limit_input,
   input  wire logic        servo_drive_end_handshake,
   output logic             step_pulse,
   output logic             dir_cw,
   output logic             busy
);
   import homing_pkg::*;

   logic            awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [1:0]      bresp_q, rresp_q;
   logic [31:0]     rdata_q;
   spec_t           spec_q;
   delays_t         dly_q;
   logic [15:0]     constant_scan_speed_q, sper_q, slow_q, margin_q;
   logic [31:0]     offset_q, cslim_q, jglim_q;
   logic            start_cw_q;
   logic [2:0]      type_q;
   state_t          state_q;
   logic [2:0]      idx_q;
   logic            extra_q, restart_q, dir_q, step_q;
   logic [7:0]      pend_dly_q, units_q;
   logic [16:0]     tick_q;
   logic [15:0]     per_q, tail_q;
   logic [31:0]     pcnt_q;
   logic            sens_prev_q, done_q, err_q, lvl_err_q, lim_seen_q;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= ADDR_STAT;
   endfunction : mapped

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // Process kind at a position of the chain
   function automatic proc_t kind(input logic [2:0] t, input logic [2:0] i, input logic x);
      logic       near;
      logic [2:0] b;
      logic [2:0] ncs;
      near = t == 3'h4 || t == 3'h5;
      b    = near ? i - 3'h1 : i;
      ncs  = x ? 3'h2 : 3'h1;
      if (near && i == 3'h0) begin
         return P_NEAR;
      end else if (b == 3'h0) begin
         return P_SCAN;
      end else if (b <= ncs) begin
         return P_CSCAN;
      end else if (b == ncs + 3'h1 && t >= 3'h2) begin
         return P_JOG;
      end
      return P_END;
   endfunction : kind

   // AXI4-Lite write channel
   logic wr_fire;
   assign wr_fire = awready_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end else begin
         awready_q <= !awready_q && awvalid && wvalid && !bvalid_q;
         wready_q  <= !awready_q && awvalid && wvalid && !bvalid_q;
         if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channel
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      unique case (araddr)
         ADDR_CTRL:   rd_mux = {27'h0, type_q, start_cw_q, 1'b0};
         ADDR_SPEC:   rd_mux = {28'h0, spec_q};
         ADDR_CONSTANT_SCAN_SPEED:   rd_mux = {16'h0, constant_scan_speed_q};
         ADDR_SPER:   rd_mux = {16'h0, sper_q};
         ADDR_SLOW:   rd_mux = {16'h0, slow_q};
         ADDR_DELAY:  rd_mux = {8'h0, dly_q};
         ADDR_MARGIN: rd_mux = {16'h0, margin_q};
         ADDR_OFFSET: rd_mux = offset_q;
         ADDR_CSLIM:  rd_mux = cslim_q;
         ADDR_JGLIM:  rd_mux = jglim_q;
         ADDR_STAT:   rd_mux = {27'h0, lim_seen_q, lvl_err_q, err_q, done_q, busy};
         default:     rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end else begin
         arready_q <= !arready_q && arvalid && !rvalid_q;
         if (arready_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Configuration registers
   logic [31:0] wm_constant_scan_speed, wm_sper, wm_slow, wm_dly, wm_mrg, wm_spec;
   assign wm_constant_scan_speed = merge({16'h0, constant_scan_speed_q}, wdata, wstrb);
   assign wm_sper = merge({16'h0, sper_q}, wdata, wstrb);
   assign wm_slow = merge({16'h0, slow_q}, wdata, wstrb);
   assign wm_dly  = merge({8'h0, dly_q}, wdata, wstrb);
   assign wm_mrg  = merge({16'h0, margin_q}, wdata, wstrb);
   assign wm_spec = merge({28'h0, spec_q}, wdata, wstrb);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         spec_q   <= '0;
         constant_scan_speed_q   <= CONSTANT_SCAN_SPEED_RST;
         sper_q   <= SPER_RST;
         slow_q   <= SLOW_RST;
         dly_q    <= '{jog: JOG_DELAY_RST, limit: LIMIT_DELAY_RST, scan: SCAN_DELAY_RST};
         margin_q <= MARGIN_RST;
         offset_q <= 32'h0;
         cslim_q  <= 32'h0;
         jglim_q  <= 32'h0;
      end else if (wr_fire) begin
         unique case (awaddr)
            ADDR_SPEC:   spec_q   <= spec_t'(wm_spec[3:0]);
            ADDR_CONSTANT_SCAN_SPEED:   constant_scan_speed_q   <= wm_constant_scan_speed[15:0];
            ADDR_SPER:   sper_q   <= wm_sper[15:0];
            ADDR_SLOW:   slow_q   <= wm_slow[15:0];
            ADDR_DELAY:  dly_q    <= delays_t'(wm_dly[23:0]);
            ADDR_MARGIN: margin_q <= wm_mrg[15:0];
            ADDR_OFFSET: if (spec_q.near_origin_move_enable) begin
               offset_q <= merge(offset_q, wdata, wstrb);
            end
            ADDR_CSLIM:  if (spec_q.error_pulse_enable) begin
               cslim_q <= merge(cslim_q, wdata, wstrb);
            end
            ADDR_JGLIM:  if (spec_q.error_pulse_enable) begin
               jglim_q <= merge(jglim_q, wdata, wstrb);
            end
            default: ;
         endcase
      end
   end

   // Sequencer decode
   proc_t       cur, nxt;
   logic        last, sens, det, lim_hit, err_hit, pulse_now, start;
   logic [15:0] scan_tail, per_len;
   assign cur  = kind(type_q, idx_q, extra_q);
   assign nxt  = kind(type_q, idx_q + 3'h1, extra_q);
   assign last = nxt == P_END;
   assign sens = cur == P_NEAR ? near_origin_sensor : origin_sensor;
   // Edge nearer the side of travel the move started from
   assign det  = cur == P_NEAR ? sens && !sens_prev_q
               : (dir_q == start_cw_q) ? sens && !sens_prev_q
               : !sens && sens_prev_q;
   assign lim_hit = dir_q ? cw_limit_input : ccw_limit_input;
   assign err_hit = spec_q.error_pulse_enable &&
                    ((cur == P_CSCAN && cslim_q != 32'h0 && pcnt_q >= cslim_q) ||
                     (cur == P_JOG && jglim_q != 32'h0 && pcnt_q >= jglim_q));
   assign scan_tail = (cur == P_SCAN && margin_q > slow_q) ? margin_q : slow_q;
   assign per_len   = cur == P_CSCAN ? constant_scan_speed_q : sper_q;
   assign pulse_now = (state_q == S_MOVE || state_q == S_TAIL || state_q == S_JOG)
                      && per_q == 16'h0;
   assign start = wr_fire && awaddr == ADDR_CTRL && wstrb[0] && wdata[CTRL_START]
                  && state_q == S_IDLE;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         per_q       <= 16'h0;
         step_q      <= 1'b0;
         sens_prev_q <= 1'b0;
      end else begin
         step_q      <= pulse_now;
         sens_prev_q <= sens;
         if (pulse_now) begin
            per_q <= per_len;
         end else if (state_q == S_MOVE || state_q == S_TAIL) begin
            per_q <= per_q - 16'h1;
         end else begin
            per_q <= 16'h0;
         end
      end
   end

   logic hand_go;
   assign hand_go = !spec_q.servo_drive_end_handshake_enable || servo_drive_end_handshake;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q    <= S_IDLE;
         idx_q      <= 3'h0;
         extra_q    <= 1'b0;
         restart_q  <= 1'b0;
         dir_q      <= 1'b0;
         start_cw_q <= 1'b0;
         type_q     <= 3'h0;
         pend_dly_q <= 8'h0;
         units_q    <= 8'h0;
         tick_q     <= 17'h0;
         tail_q     <= 16'h0;
         pcnt_q     <= 32'h0;
         busy       <= 1'b0;
         done_q     <= 1'b0;
         err_q      <= 1'b0;
         lvl_err_q  <= 1'b0;
         lim_seen_q <= 1'b0;
      end else begin
         if (pulse_now) begin
            pcnt_q <= pcnt_q + 32'h1;
         end
         unique case (state_q)
            S_IDLE: if (start) begin
               type_q     <= wdata[CTRL_TYPE +: 3];
               start_cw_q <= wdata[CTRL_CW];
               dir_q      <= wdata[CTRL_CW];
               extra_q    <= origin_sensor;
               idx_q      <= 3'h0;
               pcnt_q     <= 32'h0;
               busy       <= 1'b1;
               done_q     <= 1'b0;
               err_q      <= 1'b0;
               lvl_err_q  <= 1'b0;
               lim_seen_q <= 1'b0;
               state_q    <= S_MOVE;
            end
            S_MOVE: if (lim_hit) begin
               lim_seen_q <= 1'b1;
               if (cur == P_SCAN || cur == P_NEAR) begin
                  extra_q    <= 1'b1;
                  restart_q  <= 1'b1;
                  pend_dly_q <= dly_q.limit;
                  state_q    <= S_HAND;
               end else begin
                  err_q   <= 1'b1;
                  busy    <= 1'b0;
                  state_q <= S_IDLE;
               end
            end else if (err_hit) begin
               err_q   <= 1'b1;
               busy    <= 1'b0;
               state_q <= S_IDLE;
            end else if (det) begin
               if (cur == P_CSCAN && (last || margin_q == 16'h0)) begin
                  // Stop at once, no margin on the final process
                  if (last) begin
                     lvl_err_q <= !spec_q.ignore_level && sens != type_q[0];
                     done_q    <= 1'b1;
                     busy      <= 1'b0;
                     state_q   <= S_IDLE;
                  end else begin
                     restart_q  <= 1'b0;
                     pend_dly_q <= dly_q.scan;
                     state_q    <= S_HAND;
                  end
               end else begin
                  tail_q  <= cur == P_CSCAN ? margin_q : scan_tail;
                  state_q <= S_TAIL;
               end
            end
            S_TAIL: if (pulse_now && tail_q <= 16'h1) begin
               restart_q  <= 1'b0;
               pend_dly_q <= dly_q.scan;
               state_q    <= S_HAND;
            end else if (pulse_now) begin
               tail_q <= tail_q - 16'h1;
            end
            S_HAND: if (hand_go) begin
               if (pend_dly_q == 8'h0) begin
                  // No wait for a zero delay
                  dir_q   <= !dir_q;
                  idx_q   <= restart_q ? idx_q : idx_q + 3'h1;
                  pcnt_q  <= 32'h0;
                  state_q <= (!restart_q && nxt == P_JOG) ? S_JOG : S_MOVE;
               end else begin
                  units_q <= pend_dly_q;
                  tick_q  <= 17'h0;
                  state_q <= S_DELAY;
               end
            end
            S_DELAY: if (tick_q == 17'(DELAY_UNIT - 1)) begin
               tick_q  <= 17'h0;
               units_q <= units_q - 8'h1;
               if (units_q == 8'h1) begin
                  dir_q   <= !dir_q;
                  idx_q   <= restart_q ? idx_q : idx_q + 3'h1;
                  pcnt_q  <= 32'h0;
                  state_q <= (!restart_q && nxt == P_JOG) ? S_JOG : S_MOVE;
               end
            end else begin
               tick_q <= tick_q + 17'h1;
            end
            S_JOG: begin
               units_q <= dly_q.jog;
               tick_q  <= 17'h0;
               state_q <= S_JWAIT;
            end
            S_JWAIT: if (det) begin
               lvl_err_q <= !spec_q.ignore_level && sens != type_q[0];
               done_q    <= 1'b1;
               busy      <= 1'b0;
               state_q   <= S_IDLE;
            end else if (err_hit) begin
               err_q   <= 1'b1;
               busy    <= 1'b0;
               state_q <= S_IDLE;
            end else if (units_q == 8'h0) begin
               state_q <= S_JOG;
            end else if (tick_q == 17'(DELAY_UNIT - 1)) begin
               tick_q  <= 17'h0;
               units_q <= units_q - 8'h1;
            end else begin
               tick_q <= tick_q + 17'h1;
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   assign awready    = awready_q;
   assign wready     = wready_q;
   assign bvalid     = bvalid_q;
   assign bresp      = bresp_q;
   assign arready    = arready_q;
   assign rvalid     = rvalid_q;
   assign rdata      = rdata_q;
   assign rresp      = rresp_q;
   assign step_pulse = step_q;
   assign dir_cw     = dir_q;

   property p_margin_tail;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_MOVE && !lim_hit && !err_hit && det && cur == P_CSCAN && !last
      && margin_q != 16'h0 |=> state_q == S_TAIL && tail_q == $past(margin_q);
   endproperty
   a_margin_tail: assert property (p_margin_tail) else $error("margin tail wrong");

   property p_scan_tail;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_MOVE && !lim_hit && det && cur == P_SCAN |=> tail_q >= $past(margin_q);
   endproperty
   a_scan_tail: assert property (p_scan_tail) else $error("scan tail short");

   property p_last_stop;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_MOVE && !lim_hit && !err_hit && det && cur == P_CSCAN && last
      |=> state_q == S_IDLE && done_q;
   endproperty
   a_last_stop: assert property (p_last_stop) else $error("final process overran");

   property p_delay_load;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_HAND && hand_go && pend_dly_q != 8'h0
      |=> state_q == S_DELAY && units_q == $past(pend_dly_q);
   endproperty
   a_delay_load: assert property (p_delay_load) else $error("delay not loaded");

   property p_zero_delay;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_HAND && hand_go && pend_dly_q == 8'h0 |=> state_q inside {S_MOVE, S_JOG};
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay waited");

   property p_servo_drive_end_handshake_wait;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_HAND && spec_q.servo_drive_end_handshake_enable && !servo_drive_end_handshake |=> state_q == S_HAND;
   endproperty
   a_servo_drive_end_handshake_wait: assert property (p_servo_drive_end_handshake_wait) else $error("delay before handshake");

   property p_offset_gate;
      @(posedge aclk) disable iff (!aresetn)
      wr_fire && awaddr == ADDR_OFFSET && !spec_q.near_origin_move_enable |=> $stable(offset_q);
   endproperty
   a_offset_gate: assert property (p_offset_gate) else $error("offset written");

   property p_err_end;
      @(posedge aclk) disable iff (!aresetn)
      state_q == S_MOVE && !lim_hit && err_hit |=> state_q == S_IDLE && err_q && !busy;
   endproperty
   a_err_end: assert property (p_err_end) else $error("error not ended");

   c_done:  cover property (@(posedge aclk) disable iff (!aresetn) $rose(done_q));
   c_error: cover property (@(posedge aclk) disable iff (!aresetn) $rose(err_q));
   c_limit: cover property (@(posedge aclk) disable iff (!aresetn)
                            state_q == S_MOVE && lim_hit ##1 state_q == S_HAND);
   c_jog:   cover property (@(posedge aclk) disable iff (!aresetn) state_q == S_JOG);
endmodule : origin_return_sequencer
`default_nettype wire

/* File: motor_side_model.sv */
// Position-tracking sensor and servo drive model
`default_nettype none
module motor_side_model (
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic step_pulse,
   input  wire logic dir_cw,
   output logic      origin_sensor,
   output logic      near_origin_sensor,
   output logic      cw_limit_input,
   output logic      ccw_limit_input,
   output logic      servo_drive_end_handshake
);
   timeunit 1ns;
   timeprecision 1ps;
   int pos_q;
   int idle_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) pos_q <= 40;
      else if (step_pulse) pos_q <= dir_cw ? pos_q + 1 : pos_q - 1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) idle_q <= 0;
      else idle_q <= step_pulse ? 0 : idle_q + 1;
   end
   // Windows ten steps wide so each crossing is seen
   assign origin_sensor = pos_q >= 10 && pos_q <= 19;
   assign near_origin_sensor = pos_q >= 25 && pos_q <= 34;
   assign cw_limit_input = pos_q >= 100;
   assign ccw_limit_input = pos_q <= -20;
   // Drive settles a few cycles after the last step
   assign servo_drive_end_handshake = idle_q > 3;
endmodule : motor_side_model
`default_nettype wire

/* File: testbench.sv */
// Register and homing run checks for the sequencer
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import homing_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, r;
   logic awready, wready, bvalid, arready, rvalid, step_pulse, dir_cw, busy;
   logic origin_sensor, near_origin_sensor, cw_limit_input, ccw_limit_input;
   logic servo_drive_end_handshake;
   int n_mismatch = 0, total_checks = 0;
   origin_return_sequencer #(.DELAY_UNIT(4)) DUT (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .awaddr                    (awaddr),
      .awvalid                   (awvalid),
      .awready                   (awready),
      .wdata                     (wdata),
      .wstrb                     (wstrb),
      .wvalid                    (wvalid),
      .wready                    (wready),
      .bresp                     (bresp),
      .bvalid                    (bvalid),
      .bready                    (bready),
      .araddr                    (araddr),
      .arvalid                   (arvalid),
      .arready                   (arready),
      .rdata                     (rdata),
      .rresp                     (rresp),
      .rvalid                    (rvalid),
      .rready                    (rready),
      .origin_sensor             (origin_sensor),
      .near_origin_sensor        (near_origin_sensor),
      .cw_limit_input            (cw_limit_input),
      .ccw_limit_input           (ccw_limit_input),
      .servo_drive_end_handshake (servo_drive_end_handshake),
      .step_pulse                (step_pulse),
      .dir_cw                    (dir_cw),
      .busy                      (busy)
   );
   motor_side_model sensors (
      .aclk                      (aclk),
      .aresetn                   (aresetn),
      .step_pulse                (step_pulse),
      .dir_cw                    (dir_cw),
      .origin_sensor             (origin_sensor),
      .near_origin_sensor        (near_origin_sensor),
      .cw_limit_input            (cw_limit_input),
      .ccw_limit_input           (ccw_limit_input),
      .servo_drive_end_handshake (servo_drive_end_handshake)
   );
   initial begin
      forever #4 aclk = ~aclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   task automatic guard(inout int i);
      i++;
      if (i > 20000) begin
         n_mismatch++;
         end_sim();
      end
   endtask : guard
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
      int i = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin @(posedge aclk); guard(i); end while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      bready <= 1'b1;
      do begin @(posedge aclk); guard(i); end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      int i = 0;
      araddr <= a;
      arvalid <= 1'b1;
      do begin @(posedge aclk); guard(i); end while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do begin @(posedge aclk); guard(i); end while (rvalid !== 1'b1);
      d = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic run(input logic [31:0] ctl);
      int i = 0;
      wr(ADDR_CTRL, ctl, r);
      do begin @(posedge aclk); guard(i); end while (busy !== 1'b1);
      do begin @(posedge aclk); guard(i); end while (busy !== 1'b0);
      rd(ADDR_STAT, v, r);
   endtask : run
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ADDR_DELAY, v, r);
      chk("delays", v, {8'h00, JOG_DELAY_RST, LIMIT_DELAY_RST, SCAN_DELAY_RST});
      rd(ADDR_MARGIN, v, r);
      chk("margin", v, {16'h0000, MARGIN_RST});
      rd(8'h3c, v, r);
      chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h3c, 32'h0, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(ADDR_OFFSET, 32'h7, r);
      rd(ADDR_OFFSET, v, r);
      chk("offset off", v, 32'h0);
      wr(ADDR_CSLIM, 32'h2, r);
      rd(ADDR_CSLIM, v, r);
      chk("cslim off", v, 32'h0);
      wr(ADDR_SPEC, 32'h5, r);
      wr(ADDR_OFFSET, 32'h7, r);
      rd(ADDR_OFFSET, v, r);
      chk("offset on", v, 32'h7);
      wr(ADDR_SPER, 32'h3, r);
      wr(ADDR_CONSTANT_SCAN_SPEED, 32'h3, r);
      wr(ADDR_DELAY, 32'h00010002, r);
      // Start clockwise of the sensor, moving counter-clockwise
      run(32'h1);
      chk("status", v, 32'h2);
      chk("dir", {31'h0, dir_cw}, 32'h1);
      wr(ADDR_SPEC, 32'h2, r);
      wr(ADDR_CSLIM, 32'h2, r);
      rd(ADDR_CSLIM, v, r);
      chk("cslim on", v, 32'h2);
      wr(ADDR_JGLIM, 32'h3, r);
      rd(ADDR_JGLIM, v, r);
      chk("jglim on", v, 32'h3);
      run(32'h1);
      chk("error", v & 32'h5, 32'h4);
      wr(ADDR_SPEC, 32'h0, r);
      // Type 1 from between sensor and ccw limit, limit delay of zero units
      run(32'h5);
      chk("status t1", v, 32'h1a);
      chk("dir t1", {31'h0, dir_cw}, 32'h1);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
